// ==== verilog/tphp_host.sv ====
/*
  Host end of the token parallel port: master that owns the write token
  after reset, sends framed packets or token passes and reads the
  device's frames. Assumes the device end answers over tphp_if.
*/
`include "tphp_defs.svh"
module tphp_host #(
  parameter int ACC_CYC = `TPHP_ACC_CYC,
  parameter int GAP_CYC = `TPHP_GAP_CYC
) (
  // Clock and reset
  input  wire logic       mclk_in,
  input  wire logic       rst_n_in,
  // Parallel link
  tphp_if.host            link,
  // Mode: 1 memory-mapped slave, 0 handshake-pin slave
  input  wire logic       mode_mm_in,
  input  wire logic       realign_req_in,
  // Outgoing packet
  input  wire logic       tx_req_in,
  input  wire logic [7:0] tx_len_in,
  input  wire logic [7:0] tx_data_in,
  input  wire logic       tx_valid_in,
  output logic            tx_ready_out,
  // Incoming packet
  output logic [7:0]      rx_data_out,
  output logic            rx_valid_out,
  output logic            rx_last_out,
  // Status
  output logic            token_out,
  output logic            realign_done_out
);

  if (ACC_CYC < 6 || ACC_CYC > 15 || GAP_CYC < 2 || GAP_CYC > 15) begin : g_chk
    $error("ACC_CYC must be 6 to 15 and GAP_CYC 2 to 15");
  end

  // Link inputs, two flops deep
  logic [8:0] sync1;
  logic [8:0] sync2;
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      sync1 <= 9'h1ff;
      sync2 <= 9'h1ff;
    end else begin
      sync1 <= {link.handshake_level, link.bus};
      sync2 <= sync1;
    end
  end

  tphp_pkg::tphp_host_step_t step;
  tphp_pkg::tphp_host_step_t next_step;
  tphp_pkg::tphp_phase_t     phase;
  tphp_pkg::tphp_phase_t     next_phase;
  tphp_pkg::tphp_kind_t      kind;
  tphp_pkg::tphp_kind_t      next_kind;
  logic [3:0] pc;
  logic [3:0] next_pc;
  logic [7:0] left;
  logic [7:0] next_left;
  logic [7:0] ibyte;
  logic [7:0] next_ibyte;
  logic       rs_pend;
  logic       next_rs_pend;
  logic       cs_n;
  logic       next_cs_n;
  logic       rw;
  logic       next_rw;
  logic       sel;
  logic       next_sel;
  logic [7:0] mdata;
  logic [7:0] next_mdata;
  logic       moe;
  logic       next_moe;
  logic [7:0] next_rx_data;
  logic       next_rx_valid;
  logic       next_rx_last;
  logic       next_done;

  logic       is_wr;
  logic       flag_s;
  logic [7:0] obyte;
  logic       idle_ok;

  // Hold off a new access until the device has let go of a status read
  assign idle_ok = (pc >= 4'(GAP_CYC - 1));

  assign is_wr  = step inside {tphp_pkg::H_CMD, tphp_pkg::H_LEN,
                               tphp_pkg::H_DATA, tphp_pkg::H_END};
  assign flag_s = mode_mm_in ? sync2[0] : sync2[8];
  assign tx_ready_out = (step == tphp_pkg::H_DATA) & (phase == tphp_pkg::P_IDLE) & idle_ok;
  assign token_out    = is_wr;

  always_comb begin
    unique case (step)
      tphp_pkg::H_CMD: begin
        if (rs_pend) begin
          obyte = `TPHP_REALIGN_REQUEST;
        end else if (tx_req_in && tx_len_in != 8'h00) begin
          obyte = `TPHP_TRANSFER_START_CODE;
        end else begin
          obyte = `TPHP_NULL_CODE;
        end
      end
      tphp_pkg::H_LEN:  obyte = left;
      tphp_pkg::H_DATA: obyte = tx_data_in;
      default:          obyte = `TPHP_END_OF_MESSAGE_CODE;
    endcase
  end

  always_comb begin
    next_step     = step;
    next_phase    = phase;
    next_kind     = kind;
    next_pc       = pc + 4'h1;
    next_left     = left;
    next_ibyte    = ibyte;
    next_rs_pend  = rs_pend | realign_req_in;
    next_cs_n     = cs_n;
    next_rw       = rw;
    next_sel      = sel;
    next_mdata    = mdata;
    next_moe      = moe;
    next_rx_data  = rx_data_out;
    next_rx_valid = 1'b0;
    next_rx_last  = 1'b0;
    next_done     = 1'b0;
    unique case (phase)
      tphp_pkg::P_IDLE: begin
        if (idle_ok && (step != tphp_pkg::H_DATA || tx_valid_in)) begin
          next_phase = tphp_pkg::P_ACC;
          next_pc    = 4'h0;
          next_cs_n  = 1'b0;
          next_rw    = ~is_wr;
          next_sel   = 1'b0;
          next_mdata = obyte;
          next_moe   = is_wr;
          if (step == tphp_pkg::H_CMD) begin
            next_left = tx_len_in;
            if (rs_pend) begin
              next_kind = tphp_pkg::K_REALIGN;
            end else if (obyte == `TPHP_TRANSFER_START_CODE) begin
              next_kind = tphp_pkg::K_TRANSFER_START_CODE;
            end else begin
              next_kind = tphp_pkg::K_NULL;
            end
          end
        end
      end
      tphp_pkg::P_ACC: begin
        if (pc == 4'(ACC_CYC - 1)) begin
          if (!rw || !sel) begin
            next_ibyte = sync2[7:0];
          end
          next_cs_n  = 1'b1;
          next_moe   = 1'b0;
          next_rw    = 1'b1;
          next_sel   = 1'b0;
          next_pc    = 4'h0;
          next_phase = tphp_pkg::P_GAP;
          // Status polls never reach here; they run only in P_POLL; see below
        end
      end
      tphp_pkg::P_GAP: begin
        if (pc == 4'(GAP_CYC - 1)) begin
          next_pc    = 4'h0;
          next_phase = tphp_pkg::P_POLL;
          next_cs_n  = ~mode_mm_in;
          next_sel   = mode_mm_in;
        end
      end
      default: begin
        if (pc == 4'(ACC_CYC - 1)) begin
          next_cs_n = 1'b1;
          next_sel  = 1'b0;
          next_pc   = 4'h0;
          if (flag_s) begin
            next_phase = tphp_pkg::P_GAP;
          end else begin
            next_phase = tphp_pkg::P_IDLE;
            unique case (step)
              tphp_pkg::H_CMD: begin
                next_step = (kind == tphp_pkg::K_TRANSFER_START_CODE) ? tphp_pkg::H_LEN : tphp_pkg::H_END;
              end
              tphp_pkg::H_LEN: next_step = tphp_pkg::H_DATA;
              tphp_pkg::H_DATA: begin
                next_left = left - 8'h01;
                if (left == 8'h01) begin
                  next_step = tphp_pkg::H_END;
                end
              end
              tphp_pkg::H_END: begin
                next_step = (kind == tphp_pkg::K_REALIGN) ? tphp_pkg::H_ACKRD
                                                          : tphp_pkg::H_RX_CMD;
              end
              tphp_pkg::H_ACKRD: begin
                if (ibyte == `TPHP_REALIGN_ACK) begin
                  next_step    = tphp_pkg::H_RX_END;
                  next_rs_pend = realign_req_in;
                  next_done    = 1'b1;
                end else begin
                  next_step = tphp_pkg::H_CMD;
                end
              end
              tphp_pkg::H_RX_CMD: begin
                next_step = (ibyte == `TPHP_TRANSFER_START_CODE) ? tphp_pkg::H_RX_LEN
                                                                 : tphp_pkg::H_RX_END;
              end
              tphp_pkg::H_RX_LEN: begin
                next_left = ibyte;
                next_step = (ibyte == 8'h00) ? tphp_pkg::H_RX_END : tphp_pkg::H_RX_DATA;
              end
              tphp_pkg::H_RX_DATA: begin
                next_rx_data  = ibyte;
                next_rx_valid = 1'b1;
                next_rx_last  = (left == 8'h01);
                next_left     = left - 8'h01;
                if (left == 8'h01) begin
                  next_step = tphp_pkg::H_RX_END;
                end
              end
              default: next_step = tphp_pkg::H_CMD;
            endcase
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      step             <= tphp_pkg::H_CMD;
      phase            <= tphp_pkg::P_IDLE;
      kind             <= tphp_pkg::K_NULL;
      pc               <= 4'(GAP_CYC - 1);
      left             <= 8'h00;
      ibyte            <= 8'h00;
      rs_pend          <= 1'b0;
      cs_n             <= 1'b1;
      rw               <= 1'b1;
      sel              <= 1'b0;
      mdata            <= 8'h00;
      moe              <= 1'b0;
      rx_data_out      <= 8'h00;
      rx_valid_out     <= 1'b0;
      rx_last_out      <= 1'b0;
      realign_done_out <= 1'b0;
    end else begin
      step             <= next_step;
      phase            <= next_phase;
      kind             <= next_kind;
      pc               <= next_pc;
      left             <= next_left;
      ibyte            <= next_ibyte;
      rs_pend          <= next_rs_pend;
      cs_n             <= next_cs_n;
      rw               <= next_rw;
      sel              <= next_sel;
      mdata            <= next_mdata;
      moe              <= next_moe;
      rx_data_out      <= next_rx_data;
      rx_valid_out     <= next_rx_valid;
      rx_last_out      <= next_rx_last;
      realign_done_out <= next_done;
    end
  end

  assign link.cs_n            = cs_n;
  assign link.rw              = rw;
  assign link.register_select = sel;
  assign link.m_data          = mdata;
  assign link.m_oe            = moe;

endmodule

// ==== shared/tphp_defs.svh ====
/*
  Constants of the token parallel host port: link codes, frame limits
  and timing counts. Included by both ends; definitions only.
*/
`ifndef TPHP_DEFS_SVH
`define TPHP_DEFS_SVH

`define TPHP_END_OF_MESSAGE_CODE 8'h00
`define TPHP_NULL_CODE           8'h00
`define TPHP_TRANSFER_START_CODE 8'h01
`define TPHP_REALIGN_REQUEST     8'h5a
`define TPHP_REALIGN_ACK         8'h07
`define TPHP_MAX_LEN             255

`define TPHP_CLK_NS      25
`define TPHP_CS_MIN_NS   50
`define TPHP_CS_MIN_CYC  ((`TPHP_CS_MIN_NS + `TPHP_CLK_NS - 1) / `TPHP_CLK_NS)
`define TPHP_SYNC_RT_CYC 4
`define TPHP_ACC_CYC     (`TPHP_CS_MIN_CYC + `TPHP_SYNC_RT_CYC)
`define TPHP_GAP_CYC     3
`define TPHP_BUSY_CYC    4

`endif

// ==== shared/tphp_pkg.sv ====
/*
  Types of the token parallel host port: state encodings of both ends.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package tphp_pkg;

  typedef enum logic [8:0] {
    D_RX_CMD  = 9'h001,
    D_RX_LEN  = 9'h002,
    D_RX_DATA = 9'h004,
    D_RX_END  = 9'h008,
    D_RX_REQ  = 9'h010,
    D_TX_CMD  = 9'h020,
    D_TX_LEN  = 9'h040,
    D_TX_DATA = 9'h080,
    D_TX_END  = 9'h100
  } tphp_dev_state_t;

  typedef enum logic [8:0] {
    H_CMD     = 9'h001,
    H_LEN     = 9'h002,
    H_DATA    = 9'h004,
    H_END     = 9'h008,
    H_ACKRD   = 9'h010,
    H_RX_CMD  = 9'h020,
    H_RX_LEN  = 9'h040,
    H_RX_DATA = 9'h080,
    H_RX_END  = 9'h100
  } tphp_host_step_t;

  typedef enum logic [3:0] {
    P_IDLE = 4'h1,
    P_ACC  = 4'h2,
    P_GAP  = 4'h4,
    P_POLL = 4'h8
  } tphp_phase_t;

  typedef enum logic [1:0] {
    K_NULL    = 2'h0,
    K_TRANSFER_START_CODE    = 2'h1,
    K_REALIGN = 2'h2
  } tphp_kind_t;

endpackage

// ==== shared/tphp_if.sv ====
/*
  Parallel link between host and device: control strobes, shared byte
  bus with per-side enables and the handshake pin. Resolves wire levels;
  undriven lines read high as through pull-ups.
*/
interface tphp_if;
  logic       cs_n;
  logic       rw;
  logic       register_select;
  logic [7:0] m_data;
  logic       m_oe;
  logic [7:0] s_data;
  logic [7:0] s_oe;
  logic       handshake_pin;
  logic       handshake_pin_oe;
  logic [7:0] bus;
  logic       handshake_level;

  for (genvar i = 0; i < 8; i++) begin : g_bus
    assign bus[i] = s_oe[i] ? s_data[i] : (m_oe ? m_data[i] : 1'b1);
  end
  assign handshake_level = handshake_pin_oe ? handshake_pin : 1'b1;

  modport dev (
    input  cs_n, rw, register_select, bus,
    output s_data, s_oe, handshake_pin, handshake_pin_oe
  );
  modport host (
    output cs_n, rw, register_select, m_data, m_oe,
    input  bus, handshake_level
  );
endinterface

// ==== verilog/tphp_device.sv ====
/*
  Device end of the token parallel port: slave that receives framed
  packets while the host holds the write token and sends its own when
  it holds it. Assumes the host keeps strobes and data steady for the
  whole access and leaves gaps of at least two clocks between accesses.
*/
`include "tphp_defs.svh"
module tphp_device #(
  parameter int BUSY_CYC = `TPHP_BUSY_CYC
) (
  // Clock and reset
  input  wire logic       mclk_in,
  input  wire logic       rst_n_in,
  // Parallel link
  tphp_if.dev             link,
  // Mode: 1 memory-mapped slave, 0 handshake-pin slave
  input  wire logic       mode_mm_in,
  // Outgoing packet
  input  wire logic       tx_req_in,
  input  wire logic [7:0] tx_len_in,
  input  wire logic [7:0] tx_data_in,
  input  wire logic       tx_valid_in,
  output logic            tx_ready_out,
  // Incoming packet
  output logic [7:0]      rx_data_out,
  output logic            rx_valid_out,
  output logic            rx_last_out,
  // Status
  output logic            token_out,
  output logic            realign_done_out
);

  if (BUSY_CYC < 1 || BUSY_CYC > 15) begin : g_chk
    $error("BUSY_CYC must be 1 to 15");
  end

  // Link inputs, two flops deep
  logic [10:0] sync1;
  logic [10:0] sync2;
  logic        cs_n_s;
  logic        rw_s;
  logic        sel_s;
  logic [7:0]  bus_s;

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      sync1 <= 11'h7ff;
      sync2 <= 11'h7ff;
    end else begin
      sync1 <= {link.cs_n, link.rw, link.register_select, link.bus};
      sync2 <= sync1;
    end
  end
  assign {cs_n_s, rw_s, sel_s, bus_s} = sync2;

  tphp_pkg::tphp_dev_state_t state;
  tphp_pkg::tphp_dev_state_t next_state;
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic [3:0] busy;
  logic [3:0] next_busy;
  logic       loaded;
  logic       next_loaded;
  logic       ack_pend;
  logic       next_ack_pend;
  logic [7:0] data_reg;
  logic [7:0] next_data_reg;
  logic [7:0] wbyte;
  logic [7:0] next_wbyte;
  logic       wr_lat;
  logic       next_wr_lat;
  logic       cs_n_d;
  logic       rd_d;
  logic [7:0] drive;
  logic [7:0] next_drive;
  logic       flag;
  logic       next_flag;
  logic [7:0] next_rx_data;
  logic       next_rx_valid;
  logic       next_rx_last;
  logic       next_done;

  logic is_tx;
  logic status_rd;
  logic rd_act;
  logic rd_end;
  logic wr_end;
  logic ready_now;

  assign is_tx = state inside {tphp_pkg::D_TX_CMD, tphp_pkg::D_TX_LEN,
                               tphp_pkg::D_TX_DATA, tphp_pkg::D_TX_END};
  assign status_rd = mode_mm_in & sel_s;
  assign rd_act    = ~cs_n_s & rw_s & ~status_rd;
  // Read ends on chip select rise or on read/write fall
  assign rd_end    = rd_d & ~rd_act;
  // Writes end only on chip select rise
  assign wr_end    = cs_n_s & ~cs_n_d & wr_lat;
  assign ready_now = ~loaded & (busy == 4'h0);

  assign tx_ready_out = (state == tphp_pkg::D_TX_DATA) & ready_now;
  assign token_out    = is_tx;

  always_comb begin
    next_state    = state;
    next_cnt      = cnt;
    next_busy     = (busy != 4'h0) ? busy - 4'h1 : 4'h0;
    next_loaded   = loaded;
    next_ack_pend = ack_pend;
    next_data_reg = data_reg;
    next_wr_lat   = ~cs_n_s & ~rw_s;
    next_wbyte    = (~cs_n_s & ~rw_s) ? bus_s : wbyte;
    next_rx_data  = rx_data_out;
    next_rx_valid = 1'b0;
    next_rx_last  = 1'b0;
    next_done     = 1'b0;
    if (is_tx) begin
      if (ready_now) begin
        unique case (state)
          tphp_pkg::D_TX_CMD: begin
            next_loaded = 1'b1;
            if (ack_pend) begin
              next_data_reg = `TPHP_REALIGN_ACK;
            end else if (tx_req_in && tx_len_in != 8'h00) begin
              next_data_reg = `TPHP_TRANSFER_START_CODE;
              next_cnt      = tx_len_in;
            end else begin
              next_data_reg = `TPHP_NULL_CODE;
            end
          end
          tphp_pkg::D_TX_LEN: begin
            next_loaded   = 1'b1;
            next_data_reg = cnt;
          end
          tphp_pkg::D_TX_DATA: begin
            if (tx_valid_in) begin
              next_loaded   = 1'b1;
              next_data_reg = tx_data_in;
            end
          end
          default: begin
            next_loaded   = 1'b1;
            next_data_reg = `TPHP_END_OF_MESSAGE_CODE;
          end
        endcase
      end else if (rd_end && loaded) begin
        next_loaded = 1'b0;
        next_busy   = 4'(BUSY_CYC);
        unique case (state)
          tphp_pkg::D_TX_CMD: begin
            next_ack_pend = 1'b0;
            if (!ack_pend && data_reg == `TPHP_TRANSFER_START_CODE) begin
              next_state = tphp_pkg::D_TX_LEN;
            end else begin
              next_state = tphp_pkg::D_TX_END;
            end
          end
          tphp_pkg::D_TX_LEN: next_state = tphp_pkg::D_TX_DATA;
          tphp_pkg::D_TX_DATA: begin
            next_cnt = cnt - 8'h01;
            if (cnt == 8'h01) begin
              next_state = tphp_pkg::D_TX_END;
            end
          end
          default: next_state = tphp_pkg::D_RX_CMD;
        endcase
      end
    end else if (wr_end) begin
      next_busy = 4'(BUSY_CYC);
      unique case (state)
        tphp_pkg::D_RX_CMD: begin
          if (wbyte == `TPHP_TRANSFER_START_CODE) begin
            next_state = tphp_pkg::D_RX_LEN;
          end else if (wbyte == `TPHP_REALIGN_REQUEST) begin
            next_state = tphp_pkg::D_RX_REQ;
          end else if (wbyte == `TPHP_NULL_CODE) begin
            next_state = tphp_pkg::D_RX_END;
          end
        end
        tphp_pkg::D_RX_LEN: begin
          next_cnt   = wbyte;
          next_state = (wbyte == 8'h00) ? tphp_pkg::D_RX_END : tphp_pkg::D_RX_DATA;
        end
        tphp_pkg::D_RX_DATA: begin
          next_rx_data  = wbyte;
          next_rx_valid = 1'b1;
          next_rx_last  = (cnt == 8'h01);
          next_cnt      = cnt - 8'h01;
          if (cnt == 8'h01) begin
            next_state = tphp_pkg::D_RX_END;
          end
        end
        tphp_pkg::D_RX_END: begin
          // End code is consumed, never delivered
          if (wbyte == `TPHP_END_OF_MESSAGE_CODE) begin
            next_state = tphp_pkg::D_TX_CMD;
          end else if (wbyte == `TPHP_REALIGN_REQUEST) begin
            next_state = tphp_pkg::D_RX_REQ;
          end else begin
            next_state = tphp_pkg::D_RX_CMD;
          end
        end
        default: begin
          if (wbyte == `TPHP_END_OF_MESSAGE_CODE) begin
            next_state    = tphp_pkg::D_TX_CMD;
            next_ack_pend = 1'b1;
            next_done     = 1'b1;
          end else if (wbyte != `TPHP_REALIGN_REQUEST) begin
            next_state = tphp_pkg::D_RX_CMD;
          end
        end
      endcase
    end
    // Busy while counting down or while the outgoing byte is absent
    next_flag  = (next_busy != 4'h0) | ((next_state inside {tphp_pkg::D_TX_CMD,
                 tphp_pkg::D_TX_LEN, tphp_pkg::D_TX_DATA, tphp_pkg::D_TX_END})
                 & ~next_loaded);
    next_drive = status_rd ? {7'h00, next_flag} : next_data_reg;
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      state            <= tphp_pkg::D_RX_CMD;
      cnt              <= 8'h00;
      busy             <= 4'h0;
      loaded           <= 1'b0;
      ack_pend         <= 1'b0;
      data_reg         <= 8'h00;
      wbyte            <= 8'h00;
      wr_lat           <= 1'b0;
      cs_n_d           <= 1'b1;
      rd_d             <= 1'b0;
      drive            <= 8'h00;
      flag             <= 1'b0;
      rx_data_out      <= 8'h00;
      rx_valid_out     <= 1'b0;
      rx_last_out      <= 1'b0;
      realign_done_out <= 1'b0;
    end else begin
      state            <= next_state;
      cnt              <= next_cnt;
      busy             <= next_busy;
      loaded           <= next_loaded;
      ack_pend         <= next_ack_pend;
      data_reg         <= next_data_reg;
      wbyte            <= next_wbyte;
      wr_lat           <= next_wr_lat;
      cs_n_d           <= cs_n_s;
      rd_d             <= rd_act;
      drive            <= next_drive;
      flag             <= next_flag;
      rx_data_out      <= next_rx_data;
      rx_valid_out     <= next_rx_valid;
      rx_last_out      <= next_rx_last;
      realign_done_out <= next_done;
    end
  end

  // Bus drivers
  always_comb begin
    link.s_oe = 8'h00;
    if (!cs_n_s && rw_s) begin
      if (status_rd) begin
        link.s_oe = 8'h01;
      end else if (is_tx && loaded) begin
        link.s_oe = 8'hff;
      end
    end
  end
  assign link.s_data           = drive;
  assign link.handshake_pin    = flag;
  assign link.handshake_pin_oe = ~mode_mm_in;

endmodule

// ==== verification/tphp_checker.sv ====
/* Wire checker of the parallel link between host and device ends.
   Assumes the tphp_if signals, one clock and a sync low reset. */
module tphp_checker (
  input wire logic       mclk_in,
  input wire logic       rst_n_in,
  input wire logic       cs_n,
  input wire logic       rw,
  input wire logic       register_select,
  input wire logic       m_oe,
  input wire logic [7:0] s_oe,
  input wire logic       handshake_pin,
  input wire logic       handshake_pin_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  chk_one_driver: assert property (!(m_oe && (|s_oe)))
    else $error("both ends drive the bus");
  chk_host_writes: assert property (m_oe |-> !rw && !cs_n)
    else $error("host drives bus outside a write");
  chk_status_line: assert property ((|s_oe[7:1]) |-> handshake_pin_oe || !$past(register_select, 2))
    else $error("status read drives upper lines");
  chk_mode_steady: assert property ($stable(handshake_pin_oe))
    else $error("handshake pin enable moved");
  chk_strobe_held: assert property ($fell(cs_n) |-> !cs_n [*6])
    else $error("access strobe too short");
  chk_busy_min: assert property ($rose(handshake_pin) && handshake_pin_oe |-> handshake_pin [*4])
    else $error("busy flag too short");
  chk_flag_answer: assert property ($rose(cs_n) && !$past(rw) && handshake_pin_oe
    |-> ##[1:8] handshake_pin)
    else $error("no busy after a write");
  chk_wait_ready: assert property ($fell(cs_n) && handshake_pin_oe |-> !handshake_pin)
    else $error("access started while busy");
endmodule

// ==== verification/tb_token_parallel_host_port.sv ====
/* Bench joining the host and device ends over tphp_if.
   Assumes both ends, the package and the checker are compiled first. */
module tb_token_parallel_host_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk, rst_n, mm, rreq, htreq, dtreq, hrdy, drdy, hrv, drv, hrl, drl;
  logic       htok, dtok, hrd, drd, wr;
  logic [7:0] hlen, dlen, hrx, drx, lw;
  int         bad_count, n_compared, hi, di, hn, dn;
  logic [7:0] wq[$];
  tphp_if lk ();
  tphp_host i_tphp_host (.mclk_in(clk), .rst_n_in(rst_n), .link(lk), .mode_mm_in(mm),
    .realign_req_in(rreq), .tx_req_in(htreq), .tx_len_in(hlen), .tx_data_in(8'h10 + hi[7:0]),
    .tx_valid_in(1'b1), .tx_ready_out(hrdy), .rx_data_out(hrx), .rx_valid_out(hrv),
    .rx_last_out(hrl), .token_out(htok), .realign_done_out(hrd));
  tphp_device i_tphp_device (.mclk_in(clk), .rst_n_in(rst_n), .link(lk), .mode_mm_in(mm),
    .tx_req_in(dtreq), .tx_len_in(dlen), .tx_data_in(8'h80 + di[7:0]), .tx_valid_in(1'b1),
    .tx_ready_out(drdy), .rx_data_out(drx), .rx_valid_out(drv), .rx_last_out(drl),
    .token_out(dtok), .realign_done_out(drd));
  tphp_checker i_tphp_checker (.mclk_in(clk), .rst_n_in(rst_n), .cs_n(lk.cs_n), .rw(lk.rw),
    .register_select(lk.register_select), .m_oe(lk.m_oe), .s_oe(lk.s_oe),
    .handshake_pin(lk.handshake_pin), .handshake_pin_oe(lk.handshake_pin_oe));
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic test_done();
    $display("mismatches %0d compares %0d", bad_count, n_compared);
    if (bad_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Bounded wait on one of the scenario milestones
  task automatic wt(input int k);
    for (int i = 0; i < 5000; i++) begin
      @(negedge clk);
      if (k == 0 && dn == 3 || k == 1 && hn == 2 || k == 2 && dtok === 1'b1 ||
          k == 3 && hrd === 1'b1 || k == 4 && htok === 1'b1 || k == 5 && drd === 1'b1) return;
    end
    bad_count++;
    $display("[ERR] %0t wait %0d timed out", $time, k);
    test_done();
  endtask
  // Byte sources, receivers and a monitor of host write bytes on the wire
  always @(posedge clk) begin
    if (hrdy) hi <= hi + 1;
    if (drdy) di <= di + 1;
    if (drv) chk(drx, 8'h10 + dn[7:0]);
    if (drv) dn <= dn + 1;
    if (drv && drl) chk(dn[7:0], 8'h02);
    if (hrv) chk(hrx, 8'h80 + hn[7:0]);
    if (hrv) hn <= hn + 1;
    if (hrv && hrl) chk(hn[7:0], 8'h01);
    if (!lk.cs_n && !lk.rw && lk.m_oe) lw <= lk.bus;
    wr <= !lk.cs_n && !lk.rw;
    if (lk.cs_n && wr) wq.push_back(lw);
  end
  task automatic do_reset(input logic m);
    @(posedge clk);
    {rst_n, mm, rreq, hlen, dlen} <= {1'b0, m, 1'b0, 8'h03, 8'h02};
    {htreq, dtreq} <= 2'b11;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    {hi, di, hn, dn} <= 128'h0;
    wq.delete();
    @(negedge clk);
    chk(htok, 1'b1);
    chk(dtok, 1'b0);
  endtask
  task automatic t_transfer_start_code();
    logic [7:0] e[6];
    e = '{8'h01, 8'h03, 8'h10, 8'h11, 8'h12, 8'h00};
    wt(0);
    @(posedge clk) htreq <= 1'b0;
    wt(2);
    for (int i = 0; i < 6; i++) chk(wq[i], e[i]);
  endtask
  task automatic t_back();
    wt(1);
    @(posedge clk) dtreq <= 1'b0;
    wt(4);
    chk(dtok, 1'b0);
    chk(hn[7:0], 8'h02);
    chk(dn[7:0], 8'h03);
  endtask
  task automatic t_realign();
    logic f;
    f = 0;
    wt(2);
    wq.delete();
    @(posedge clk) rreq <= 1'b1;
    @(posedge clk) rreq <= 1'b0;
    wt(5);
    wt(3);
    wt(4);
    chk(htok, 1'b1);
    chk(dtok, 1'b0);
    foreach (wq[i]) if (wq[i] === 8'h5a) f = 1;
    chk(f, 1'b1);
  endtask
  initial begin
    rst_n = 1'b0;
    mm = 1'b0;
    bad_count = 0;
    n_compared = 0;
    for (int m = 0; m < 2; m++) begin
      do_reset(m[0]);
      t_transfer_start_code();
      t_back();
      t_realign();
    end
    test_done();
  end
endmodule
